// ### pdat_pkg.sv
package pdat_pkg;
    // Register map
    localparam logic [7:0] PDAT_ADDR_POWER = 8'hB4;
    localparam logic [7:0] PDAT_ADDR_TRIG = 8'hC0;
    localparam logic [7:0] PDAT_ADDR_TEMP_LO = 8'hD0;
    localparam logic [7:0] PDAT_ADDR_TEMP_HI = 8'hD1;
    localparam logic [7:0] PDAT_ADDR_AIN_LO = 8'hD2;
    localparam logic [7:0] PDAT_ADDR_AIN_HI = 8'hD3;
    localparam logic [7:0] PDAT_ADDR_STATUS = 8'hD4;
    // Field positions and reset values
    localparam int PDAT_BIT_ADC_EN = 0;
    localparam int PDAT_BIT_REF_EN = 1;
    localparam int PDAT_BIT_TRIG = 0;
    localparam logic [7:0] PDAT_RESET_POWER = 8'h00;
    localparam logic [7:0] PDAT_RESET_TRIG = 8'h00;
    localparam logic [11:0] PDAT_RESET_RESULT = 12'h000;
    // Timing: 4 MHz converter oscillator derived from the 20 MHz clock
    localparam int PDAT_CLK_HZ = 20_000_000;
    localparam int PDAT_OSC_HZ = 4_000_000;
    localparam int PDAT_OSC_DIV = PDAT_CLK_HZ / PDAT_OSC_HZ;
    localparam int PDAT_CONV_OSC_CLKS = 138;
    localparam int PDAT_TEMP_OSC_CLKS = 1025;
endpackage

// ### pdat_conv_seq.sv
`timescale 1ns/1ps
`default_nettype none
module pdat_conv_seq #(
    parameter int DIV = 5,
    parameter int AIN_CLKS = 138,
    parameter int TEMP_CLKS = 1025
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic start,
    // Status
    output logic busy,
    output logic done
);
    typedef enum logic [2:0] {
        PDAT_IDLE = 3'b001,
        PDAT_AIN = 3'b010,
        PDAT_TEMP = 3'b100
    } pdat_seq_t;

    pdat_seq_t state_r, state_nxt;
    logic [15:0] div_r;
    logic [15:0] cnt_r;
    wire osc_tick = (div_r == 16'(DIV - 1));
    wire cnt_last_ain = (cnt_r == 16'(AIN_CLKS - 1));
    wire cnt_last_temp = (cnt_r == 16'(TEMP_CLKS - 1));

    // Sequence: analog channel, then temperature channel
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PDAT_IDLE: if (start) state_nxt = PDAT_AIN;
            PDAT_AIN: if (osc_tick && cnt_last_ain) state_nxt = PDAT_TEMP;
            PDAT_TEMP: if (osc_tick && cnt_last_temp) state_nxt = PDAT_IDLE;
            default: state_nxt = PDAT_IDLE;
        endcase
    end

    // Oscillator divider and clock counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= PDAT_IDLE;
            div_r <= 16'h0000;
            cnt_r <= 16'h0000;
            done <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            done <= (state_r == PDAT_TEMP) && (state_nxt == PDAT_IDLE);
            if (state_r == PDAT_IDLE || osc_tick) div_r <= 16'h0000;
            else div_r <= div_r + 16'h0001;
            if (state_nxt != state_r) cnt_r <= 16'h0000;
            else if (osc_tick) cnt_r <= cnt_r + 16'h0001; // see [R09]
        end
    end

    assign busy = (state_r != PDAT_IDLE);
endmodule
`default_nettype wire

// ### pdat_regs.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R01] Power register bit1 reference, bit0 converter
// [R02] Reset clears power register to zero
// [R03] Disabled reference or converter stays low power
// [R04] Host keeps reserved upper bits zero
// [R05] Trigger bit one starts a conversion
// [R06] Trigger bit self-clears once conversion starts
// [R07] Trigger register resets to zero
// [R08] Results refresh after every completed conversion
// [R09] Conversion timing counts 4 MHz oscillator clocks
// [R10] Trigger ignored and cleared while converter off
module pdat_regs
    import pdat_pkg::*;
#(
    parameter int OSC_DIV = pdat_pkg::PDAT_OSC_DIV,
    parameter int AIN_CLKS = pdat_pkg::PDAT_CONV_OSC_CLKS,
    parameter int TEMP_CLKS = pdat_pkg::PDAT_TEMP_OSC_CLKS
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Converter data path
    input wire logic [11:0] temp_sample,
    input wire logic [11:0] ain_sample,
    // Analog power controls and conversion busy status
    output logic reference_power_enable,
    output logic converter_power_enable,
    output logic conv_busy
);
    import pdat_pkg::*;

    logic [7:0] power_r;
    logic [7:0] trig_r;
    logic [11:0] temp_r;
    logic [11:0] ain_r;
    logic [7:0] rdata_nxt;
    logic seq_busy;
    logic seq_done;

    // Address decode
    wire wr_power = wr && (addr == PDAT_ADDR_POWER);
    wire wr_trig = wr && (addr == PDAT_ADDR_TRIG);
    wire conversion_trigger_bit = trig_r[PDAT_BIT_TRIG];
    wire adc_on = power_r[PDAT_BIT_ADC_EN];
    wire start = conversion_trigger_bit && adc_on && !seq_busy; // see [R05] see [R10]

    // Readback mux; unmapped addresses read zero
    always_comb begin
        case (addr)
            PDAT_ADDR_POWER: rdata_nxt = power_r;
            PDAT_ADDR_TRIG: rdata_nxt = trig_r;
            PDAT_ADDR_TEMP_LO: rdata_nxt = temp_r[7:0];
            PDAT_ADDR_TEMP_HI: rdata_nxt = {4'h0, temp_r[11:8]};
            PDAT_ADDR_AIN_LO: rdata_nxt = ain_r[7:0];
            PDAT_ADDR_AIN_HI: rdata_nxt = {4'h0, ain_r[11:8]};
            PDAT_ADDR_STATUS: rdata_nxt = {7'h00, seq_busy};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Power control register, all bits stored as written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_r <= PDAT_RESET_POWER; // see [R02]
        end else if (ce && wr_power) begin
            power_r <= wdata; // see [R01] see [R04]
        end
    end

    // Trigger register; host write wins, else bit clears when taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_r <= PDAT_RESET_TRIG; // see [R07]
        end else if (ce) begin
            if (wr_trig) trig_r <= wdata;
            else if (conversion_trigger_bit && (start || !adc_on))
                trig_r[PDAT_BIT_TRIG] <= 1'b0; // see [R06] see [R10]
        end
    end

    // Result capture at end of sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            temp_r <= PDAT_RESET_RESULT;
            ain_r <= PDAT_RESET_RESULT;
        end else if (ce && seq_done) begin
            temp_r <= temp_sample; // see [R08]
            ain_r <= ain_sample; // see [R08]
        end
    end

    // Registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            reference_power_enable <= 1'b0;
            converter_power_enable <= 1'b0;
            conv_busy <= 1'b0;
        end else if (ce) begin
            rdata <= rd ? rdata_nxt : 8'h00;
            reference_power_enable <= power_r[PDAT_BIT_REF_EN]; // see [R03]
            converter_power_enable <= power_r[PDAT_BIT_ADC_EN]; // see [R03]
            conv_busy <= seq_busy;
        end
    end

    // Conversion sequencer
    pdat_conv_seq #(
        .DIV(OSC_DIV),
        .AIN_CLKS(AIN_CLKS),
        .TEMP_CLKS(TEMP_CLKS)
    ) u_seq (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(start),
        .busy(seq_busy),
        .done(seq_done)
    );

    // Trigger ignored while converter off
    trig_off_a: assert property (@(posedge clk) disable iff (rst) // see [R10]
        (ce && conversion_trigger_bit && !adc_on && !wr_trig) |=> !seq_busy || $past(seq_busy))
        else $error("trigger started conversion while off");

    // Self clear after start
    trig_clear_a: assert property (@(posedge clk) disable iff (rst) // see [R06]
        (ce && start && !wr_trig) |=> !trig_r[PDAT_BIT_TRIG])
        else $error("trigger bit not cleared");

    // Start launches sequencer
    start_busy_a: assert property (@(posedge clk) disable iff (rst) // see [R05]
        (ce && start) |=> seq_busy)
        else $error("conversion did not start");

    // Results change only on done
    result_hold_a: assert property (@(posedge clk) disable iff (rst) // see [R08]
        (!(ce && seq_done)) |=> $stable(ain_r) && $stable(temp_r))
        else $error("result changed without conversion");

    // Power enable follows register
    power_out_a: assert property (@(posedge clk) disable iff (rst) // see [R01]
        (ce && wr_power) |=> ##1 (reference_power_enable == $past(wdata[1], 2)))
        else $error("reference enable mismatch");

    // Converter off keeps enable low
    adc_low_a: assert property (@(posedge clk) disable iff (rst) // see [R03]
        (!power_r[PDAT_BIT_ADC_EN] && ce) |=> !converter_power_enable)
        else $error("converter enabled while off");

    // Reset values
    reset_val_a: assert property (@(posedge clk) // see [R02]
        rst |-> (power_r == 8'h00))
        else $error("power register not reset");

    trig_reset_a: assert property (@(posedge clk) // see [R07]
        rst |-> (trig_r == 8'h00))
        else $error("trigger register not reset");
endmodule
`default_nettype wire

// ### pdat_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdat_adc_model #(
    parameter logic [11:0] TEMP_VAL = 12'hA5C,
    parameter logic [11:0] AIN_VAL = 12'h3E7
) (
    // Clock and power
    input wire logic clk,
    input wire logic powered,
    // Raw samples
    output logic [11:0] temp_sample,
    output logic [11:0] ain_sample
);
    logic [11:0] junk_r = 12'h000;
    // Changing pattern so a stale value never passes
    always @(posedge clk) begin
        junk_r <= junk_r + 12'h0A7;
    end
    // Valid levels only while the converter is powered
    assign temp_sample = powered ? TEMP_VAL : junk_r;
    assign ain_sample = powered ? AIN_VAL : ~junk_r;
endmodule
`default_nettype wire

// ### power_down_and_adc_trigger_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_down_and_adc_trigger_regs_tb;
    import pdat_pkg::*;
    logic clk, rst, ce, wr, rd, ref_en, cnv_en, conv_busy;
    logic [7:0] addr, wdata, rdata, v;
    logic [11:0] temp_sample, ain_sample;
    int n_fail = 0;
    int n_checks = 0;
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    pdat_regs #(.OSC_DIV(1), .AIN_CLKS(4), .TEMP_CLKS(4)) dut (.clk(clk), .rst(rst),
        .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .temp_sample(temp_sample), .ain_sample(ain_sample),
        .reference_power_enable(ref_en), .converter_power_enable(cnv_en),
        .conv_busy(conv_busy));
    pdat_adc_model model (.clk(clk), .powered(cnv_en), .temp_sample(temp_sample),
        .ain_sample(ain_sample));
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Compare seen against expected
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read strobe, data in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Bounded wait for a busy level
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 100 && conv_busy !== lvl; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 100) begin
            n_fail++;
            end_sim();
        end
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(PDAT_ADDR_POWER, v);
        chk("power reset", v, PDAT_RESET_POWER);
        rd_reg(PDAT_ADDR_TRIG, v);
        chk("trigger reset", v, PDAT_RESET_TRIG);
        chk("enables off", {6'h00, ref_en, cnv_en}, 8'h00);
        // Trigger while converter is off is dropped
        wr_reg(PDAT_ADDR_TRIG, 8'h01);
        repeat (4) @(posedge clk);
        #1;
        chk("idle busy", {7'h00, conv_busy}, 8'h00);
        rd_reg(PDAT_ADDR_TRIG, v);
        chk("dropped trigger", v, 8'h00);
        rd_reg(PDAT_ADDR_TEMP_LO, v);
        chk("untouched result", v, 8'h00);
        // Read data stands for one cycle only
        @(posedge clk);
        #1;
        chk("idle rdata", rdata, 8'h00);
        // Reference alone, then both
        wr_reg(PDAT_ADDR_POWER, 8'h02);
        rd_reg(PDAT_ADDR_POWER, v);
        chk("power ref", v, 8'h02);
        chk("ref enable", {6'h00, ref_en, cnv_en}, 8'h02);
        wr_reg(PDAT_ADDR_POWER, 8'h03);
        rd_reg(PDAT_ADDR_POWER, v);
        chk("both enables", {6'h00, ref_en, cnv_en}, 8'h03);
        // Full conversion and result refresh
        wr_reg(PDAT_ADDR_TRIG, 8'h01);
        wait_busy(1'b1);
        rd_reg(PDAT_ADDR_TRIG, v);
        chk("self clear", v, 8'h00);
        rd_reg(PDAT_ADDR_STATUS, v);
        chk("status busy", v, 8'h01);
        wait_busy(1'b0);
        rd_reg(PDAT_ADDR_STATUS, v);
        chk("status idle", v, 8'h00);
        rd_reg(PDAT_ADDR_TEMP_LO, v);
        chk("temp lo", v, 8'h5C);
        rd_reg(PDAT_ADDR_TEMP_HI, v);
        chk("temp hi", v, 8'h0A);
        rd_reg(PDAT_ADDR_AIN_LO, v);
        chk("ain lo", v, 8'hE7);
        rd_reg(PDAT_ADDR_AIN_HI, v);
        chk("ain hi", v, 8'h03);
        // Write with clock enable low is frozen out
        ce <= 1'b0;
        wr_reg(PDAT_ADDR_POWER, 8'h00);
        ce <= 1'b1;
        rd_reg(PDAT_ADDR_POWER, v);
        chk("frozen write", v, 8'h03);
        rd_reg(8'h10, v);
        chk("unmapped", v, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
